// [pkg/ccds_map.vh]
// register map, trigger mode codes, reset values and timing counts
`ifndef CCDS_MAP_VH
`define CCDS_MAP_VH
`define CCDS_ADDR_CTRL    4'h0
`define CCDS_ADDR_EXPO    4'h4
`define CCDS_ADDR_ROI     4'h8
`define CCDS_ADDR_GEOM    4'hc
`define CCDS_ADDR_STAT    4'h0
`define CCDS_CTRL_RESET   32'h0000_0004
`define CCDS_EXPO_RESET   32'h0000_03e8
`define CCDS_ROI_RESET    32'h0000_0000
`define CCDS_GEOM_RESET   32'h0008_0008
`define CCDS_TRG_IGNORE   2'h0
`define CCDS_TRG_ONCE     2'h1
`define CCDS_TRG_PER      2'h2
`define CCDS_TRG_LEVEL    2'h3
`define CCDS_CLK_HZ       40000000
`define CCDS_SLOW_HZ      100000
`define CCDS_FAST_HZ      2000000
`define CCDS_SLOW_CYC     (`CCDS_CLK_HZ / `CCDS_SLOW_HZ)
`define CCDS_FAST_CYC     (`CCDS_CLK_HZ / `CCDS_FAST_HZ)
`define CCDS_BIAS_OFFSET  16'h0226
`define CCDS_FULL_SCALE   16'hffff
`define CCDS_VSHIFT_CYC   16'h0028
`define CCDS_SHUT_OPEN_CYC 16'h0010
`define CCDS_SHUT_CLOSE_CYC 16'h0010
`endif

// [src/ccds_pace.v]
// down counter that paces one timed step of the sequencer
`timescale 1ns/10ps
module ccds_pace (
	input  wire        ref_clk, // system clock
	input  wire        rst,     // async reset, high
	input  wire        load,    // start a period
	input  wire [31:0] count,   // length in cycles, minus one
	output wire        done     // period finished
);
	reg [31:0] cnt_r; // remaining cycles

	// count down, hold at zero
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			cnt_r <= 32'h0;
		else if (load)
			cnt_r <= count;
		else if (cnt_r != 32'h0)
			cnt_r <= cnt_r - 32'h1;
	end
	// done ignores load: open, close, shift and pixel steps raise load from done, so no loop
	assign done = (cnt_r == 32'h0);
endmodule // ccds_pace

// [src/ccds_sequencer.v]
// full-frame readout sequencer with an AXI4-Lite register slave
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "ccds_map.vh"
module ccds_sequencer (
	input  wire        ref_clk,        // 40 MHz clock
	input  wire        rst,            // async reset, high
	input  wire [3:0]  s_axi_awaddr,   // write address
	input  wire        s_axi_awvalid,  // write address valid
	output reg         s_axi_awready,  // write address ready
	input  wire [31:0] s_axi_wdata,    // write data
	input  wire [3:0]  s_axi_wstrb,    // write strobes
	input  wire        s_axi_wvalid,   // write data valid
	output reg         s_axi_wready,   // write data ready
	output reg  [1:0]  s_axi_bresp,    // write response
	output reg         s_axi_bvalid,   // write response valid
	input  wire        s_axi_bready,   // write response ready
	input  wire [3:0]  s_axi_araddr,   // read address
	input  wire        s_axi_arvalid,  // read address valid
	output reg         s_axi_arready,  // read address ready
	output reg  [31:0] s_axi_rdata,    // read data
	output reg  [1:0]  s_axi_rresp,    // read response
	output reg         s_axi_rvalid,   // read data valid
	input  wire        s_axi_rready,   // read data ready
	input  wire        external_trigger_input, // trigger pin
	input  wire [15:0] adcData,        // raw conversion result
	output reg         vShift_r,       // vertical transfer pulse
	output reg         hShift_r,       // serial register step
	output reg         adcConvert_r,   // conversion strobe
	output reg         shutterOpen_r,  // shutter drive
	output reg         gainHigh_r,     // preamp gain select
	output reg  [15:0] pixData_r,      // corrected sample
	output reg         pixValid_r,     // sample strobe
	output reg         frameDone_r     // end of frame pulse
);
	// software registers
	reg [31:0] ctrl_r; // [0]start [1]fast [2]bias [3]gain [5:4]mode [6]fall
	reg [31:0] expo_r; // exposure cycles
	reg [31:0] roi_r;  // [15:0] first col, [31:16] col count
	reg [31:0] geom_r; // [15:0] columns, [31:16] rows
	// frame-latched settings
	reg        fast_r, bias_r;   // rate and correction for this frame
	reg [15:0] cols_r, rows_r;   // geometry this frame
	reg [15:0] roiLo_r, roiHi_r; // kept column window
	reg [1:0]  mode_r;           // trigger mode this frame
	// sequencer
	localparam ST_IDLE = 7'h01, ST_OPEN = 7'h02, ST_EXPO = 7'h04,
		ST_CLOSE = 7'h08, ST_VSH = 7'h10, ST_PIX = 7'h20, ST_DONE = 7'h40;
	reg [6:0]  state_r;        // one-hot state
	reg [15:0] row_r, col_r;   // position in the frame
	reg        refRow_r;       // reading the reference row
	reg [31:0] accum_r;        // reference row sum
	reg [15:0] biasAvg_r;      // reference row average
	reg        onceArmed_r;    // start-once sequence running
	reg        trigPrev_r;     // trigger history for edges
	reg        load;           // timer load
	reg [31:0] loadVal;        // timer length
	wire       tDone;          // timer finished
	wire       trigActive = ctrl_r[6] ? ~external_trigger_input
		: external_trigger_input;
	wire       trigEdge = ctrl_r[6] ? (trigPrev_r & ~external_trigger_input)
		: (~trigPrev_r & external_trigger_input);
	// timer runs load value plus one cycles, hence the minus one
	wire [31:0] pixCyc = (fast_r ? `CCDS_FAST_CYC : `CCDS_SLOW_CYC)
		- 32'h1;
	wire [16:0] sum = {1'b0, adcData} + {1'b0, `CCDS_BIAS_OFFSET};
	wire [16:0] sub = bias_r ? {1'b0, biasAvg_r} : 17'h0;
	wire [16:0] corr = sum - sub;
	// below zero clamps to zero, above full scale to full scale
	wire [15:0] clamped = (sum < sub) ? 16'h0
		: (corr[16] ? `CCDS_FULL_SCALE : corr[15:0]);
	wire [31:0] avgQ = (cols_r == 16'h0) ? 32'h0
		: (accum_r + {16'h0, adcData}) / {16'h0, cols_r};
	reg        capRef_r;       // pending conversion is a reference pixel
	reg        capKeep_r;      // pending conversion is a kept pixel
	reg        capLast_r;      // pending conversion ends the reference row
	wire       inRoi = (roi_r[31:16] == 16'h0) ||
		(col_r >= roiLo_r && col_r < roiHi_r);
	wire       lastCol = (col_r == cols_r - 16'h1);
	wire       lastRow = (row_r == rows_r - 16'h1);

	ccds_pace u_pace (
		.ref_clk (ref_clk),
		.rst     (rst),
		.load    (load),
		.count   (loadVal),
		.done    (tDone)
	);

	// bus slave: takes aw and w in either order, answers after both
	reg awHeld_r, wHeld_r; // channel captured
	reg [3:0]  awAddr_r;   // captured address
	reg [31:0] wData_r;    // captured data
	reg [3:0]  wStrb_r;    // captured strobes
	wire doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= 4'h0;
			wData_r  <= 32'h0;
			wStrb_r  <= 4'h0;
			ctrl_r <= `CCDS_CTRL_RESET;
			expo_r <= `CCDS_EXPO_RESET;
			roi_r  <= `CCDS_ROI_RESET;
			geom_r <= `CCDS_GEOM_RESET;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				awAddr_r <= s_axi_awaddr;
				awHeld_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				wHeld_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// start bit self-clears whenever the sequencer is idle; only the ignore mode starts a frame on it
			if (state_r == ST_IDLE && ctrl_r[0])
				ctrl_r[0] <= 1'b0;
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				case (awAddr_r)
				`CCDS_ADDR_CTRL: if (wStrb_r[0]) ctrl_r[7:0] <= wData_r[7:0];
				`CCDS_ADDR_EXPO: expo_r <= wData_r;
				`CCDS_ADDR_ROI:  roi_r  <= wData_r;
				`CCDS_ADDR_GEOM: geom_r <= wData_r;
				default: s_axi_bresp <= 2'h2; // unmapped: slave error
				endcase
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read channel: one cycle after the address, held until rready
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'h0;
			case (s_axi_araddr)
			`CCDS_ADDR_STAT: s_axi_rdata <= {9'h0, state_r, biasAvg_r};
			`CCDS_ADDR_EXPO: s_axi_rdata <= expo_r;
			`CCDS_ADDR_ROI:  s_axi_rdata <= roi_r;
			`CCDS_ADDR_GEOM: s_axi_rdata <= geom_r;
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// timer loads, decided from the current state
	always @* begin
		load = 1'b0;
		loadVal = 32'h0;
		case (state_r)
		ST_OPEN: if (tDone) begin
			load = 1'b1;
			loadVal = (expo_r == 32'h0) ? 32'h0 : expo_r - 32'h1;
		end
		ST_IDLE: begin
			load = 1'b1;
			loadVal = {16'h0, `CCDS_SHUT_OPEN_CYC - 16'h1};
		end
		ST_EXPO: if ((mode_r == `CCDS_TRG_LEVEL) ? ~trigActive : tDone) begin
			load = 1'b1;
			loadVal = {16'h0, `CCDS_SHUT_CLOSE_CYC - 16'h1};
		end
		ST_CLOSE: if (tDone) begin
			load = 1'b1;
			loadVal = {16'h0, `CCDS_VSHIFT_CYC - 16'h1};
		end
		ST_VSH: if (tDone) begin
			load = 1'b1;
			loadVal = pixCyc;
		end
		ST_PIX: if (tDone) begin
			load = 1'b1;
			loadVal = lastCol ? {16'h0, `CCDS_VSHIFT_CYC - 16'h1} : pixCyc;
		end
		default: begin
			load = 1'b0;
			loadVal = 32'h0;
		end
		endcase
	end

	// frame sequencer
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			fast_r <= 1'b0; bias_r <= 1'b1;
			cols_r <= 16'h0; rows_r <= 16'h0;
			roiLo_r <= 16'h0; roiHi_r <= 16'h0;
			mode_r <= `CCDS_TRG_IGNORE;
			row_r <= 16'h0; col_r <= 16'h0;
			refRow_r <= 1'b0; accum_r <= 32'h0; biasAvg_r <= 16'h0;
			onceArmed_r <= 1'b0; trigPrev_r <= 1'b0;
			capRef_r <= 1'b0;
			capKeep_r <= 1'b0;
			capLast_r <= 1'b0;
			vShift_r <= 1'b0; hShift_r <= 1'b0; adcConvert_r <= 1'b0;
			shutterOpen_r <= 1'b0; gainHigh_r <= 1'b0;
			pixData_r <= 16'h0; pixValid_r <= 1'b0; frameDone_r <= 1'b0;
		end else begin
			trigPrev_r <= external_trigger_input;
			vShift_r <= 1'b0;
			hShift_r <= 1'b0;
			adcConvert_r <= 1'b0;
			pixValid_r <= 1'b0;
			frameDone_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				// ignore: software start; once: first edge then free run
				if ((ctrl_r[5:4] == `CCDS_TRG_IGNORE && ctrl_r[0]) ||
					(ctrl_r[5:4] == `CCDS_TRG_ONCE &&
					 (onceArmed_r || trigEdge)) ||
					(ctrl_r[5:4] == `CCDS_TRG_PER && trigEdge) ||
					(ctrl_r[5:4] == `CCDS_TRG_LEVEL && trigActive)) begin
					fast_r <= ctrl_r[1];
					bias_r <= ctrl_r[2];
					gainHigh_r <= ctrl_r[3];
					mode_r <= ctrl_r[5:4];
					onceArmed_r <= (ctrl_r[5:4] == `CCDS_TRG_ONCE);
					cols_r <= geom_r[15:0];
					rows_r <= geom_r[31:16];
					roiLo_r <= roi_r[15:0];
					roiHi_r <= roi_r[15:0] + roi_r[31:16];
					shutterOpen_r <= 1'b1;
					state_r <= ST_OPEN;
				end
			end
			ST_OPEN: if (tDone) state_r <= ST_EXPO; // open compensation
			ST_EXPO: if (load) begin
				shutterOpen_r <= 1'b0;
				state_r <= ST_CLOSE;
			end
			ST_CLOSE: if (tDone) begin
				row_r <= 16'h0;
				refRow_r <= bias_r;
				accum_r <= 32'h0;
				vShift_r <= ~bias_r;
				state_r <= ST_VSH;
			end
			ST_VSH: if (tDone) begin
				col_r <= 16'h0;
				state_r <= ST_PIX;
			end
			ST_PIX: if (tDone) begin
				hShift_r <= 1'b1;
				adcConvert_r <= 1'b1;
				// note what this conversion is for; it lands next cycle
				capRef_r <= refRow_r;
				capKeep_r <= ~refRow_r & inRoi;
				capLast_r <= refRow_r & lastCol;
				col_r <= col_r + 16'h1;
				if (lastCol) begin
					if (refRow_r) begin
						refRow_r <= 1'b0;
						state_r <= ST_VSH;
					end else if (lastRow) begin
						state_r <= ST_DONE;
					end else begin
						row_r <= row_r + 16'h1;
						state_r <= ST_VSH;
					end
				end
			end
			// done waits for the final conversion to land
			ST_DONE: begin
				frameDone_r <= 1'b1;
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
			// the node holds the stepped pixel while the strobe stands
			if (adcConvert_r) begin
				if (capRef_r)
					accum_r <= accum_r + {16'h0, adcData};
				if (capLast_r)
					biasAvg_r <= avgQ[15:0];
				if (capKeep_r) begin
					pixValid_r <= 1'b1;
					pixData_r <= clamped;
				end
				// rows move only once the last pixel is digitized
				if (state_r == ST_VSH)
					vShift_r <= 1'b1;
			end
		end
	end
endmodule // ccds_sequencer

// [bench/ccds_checker.sv]
// port checks for the readout sequencer
`timescale 1ns/10ps
module ccds_checker (
	input logic ref_clk,       // clock
	input logic rst,           // reset
	input logic s_axi_awvalid, // aw valid
	input logic s_axi_awready, // aw ready
	input logic s_axi_wvalid,  // w valid
	input logic s_axi_wready,  // w ready
	input logic s_axi_bvalid,  // b valid
	input logic s_axi_arvalid, // ar valid
	input logic s_axi_arready, // ar ready
	input logic s_axi_rvalid,  // r valid
	input logic vShift_r,      // row shift
	input logic hShift_r,      // pixel step
	input logic adcConvert_r,  // convert
	input logic shutterOpen_r, // shutter
	input logic gainHigh_r,    // gain
	input logic pixValid_r,    // sample
	input logic frameDone_r    // frame end
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// light must be off the array while it is read
	shut_read_a: assert property (pixValid_r |-> !shutterOpen_r)
		else $error("sample while shutter open");
	shift_order_a: assert property (
		vShift_r |-> !hShift_r && !adcConvert_r)
		else $error("row shift during serial step");
	pix_gap_a: assert property (pixValid_r |=> !pixValid_r [*8])
		else $error("samples too close");
	vshift_gap_a: assert property (vShift_r |=> !vShift_r [*8])
		else $error("row shifts too close");
	// opening compensation keeps the shutter up for a while
	shut_hold_a: assert property (
		$rose(shutterOpen_r) |=> shutterOpen_r [*8])
		else $error("shutter open too short");
	frame_end_a: assert property (frameDone_r |-> !shutterOpen_r)
		else $error("frame end with shutter open");
	gain_hold_a: assert property (
		$changed(gainHigh_r) |-> !pixValid_r && !vShift_r)
		else $error("gain moved inside readout");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read response late");
	cover property (pixValid_r);
	cover property (frameDone_r);
	cover property ($rose(shutterOpen_r));
endmodule // ccds_checker

bind ccds_sequencer ccds_checker ccds_checker_i (.ref_clk, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.vShift_r, .hShift_r, .adcConvert_r, .shutterOpen_r, .gainHigh_r,
	.pixValid_r, .frameDone_r);

// [bench/ccds_ccd_model.sv]
// array and output node seen by the sequencer
`timescale 1ns/10ps
module ccds_ccd_model (
	input  wire        ref_clk,      // clock
	input  wire        rst,          // reset
	input  wire        hShift_r,     // serial step
	input  wire        adcConvert_r, // conversion
	input  wire [15:0] level,        // pixel charge
	output wire [15:0] adcData       // node value
);
	reg chargedR_r; // node holds a pixel
	// a step fills the node, a conversion empties it
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			chargedR_r <= 1'h0;
		else if (hShift_r)
			chargedR_r <= 1'h1;
		else if (adcConvert_r)
			chargedR_r <= 1'h0;
	end
	// empty node shows the inverse so a stale read is caught
	assign adcData = (chargedR_r | hShift_r) ? level : ~level;
endmodule // ccds_ccd_model

// [bench/tb_ccd_full_frame_readout_sequencer.sv]
// self-checking bench for the readout sequencer
`timescale 1ns/10ps
`include "ccds_map.vh"
module tb_ccd_full_frame_readout_sequencer;
	typedef struct {logic [7:0] ctrl; logic [1:0] trg;
		logic [15:0] lvl, pix;} ccds_row_t;
	logic        ref_clk = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, expG = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, chkOn = 1'h0;
	logic        external_trigger_input = 1'h0; // trigger pin
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0]  s_axi_wstrb = 4'hf; // whole word always
	logic [31:0] s_axi_wdata = 32'h0, rdVal;
	logic [15:0] level = 16'h0, expD = 16'h0; // charge, expected sample
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire         s_axi_rvalid, vShift_r, hShift_r, adcConvert_r;
	wire         shutterOpen_r, gainHigh_r, pixValid_r, frameDone_r;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [15:0] adcData, pixData_r;
	int          fail_count = 0, n_checks = 0, nPix = 0, gap = 0, minGap;
	int          len [8];
	time         t0;
	// ctrl, trigger kind, charge level, expected sample
	ccds_row_t rows [8] = '{
		'{8'h03, 2'h0, 16'h1000, 16'h1226}, '{8'h0b, 2'h0, 16'hff00, 16'hffff},
		'{8'h07, 2'h0, 16'h1000, 16'h0226}, '{8'h01, 2'h0, 16'h0000, 16'h0226},
		'{8'h22, 2'h1, 16'h0100, 16'h0326}, '{8'h62, 2'h2, 16'h0100, 16'h0326},
		'{8'h32, 2'h3, 16'h0200, 16'h0426}, '{8'h12, 2'h1, 16'h0300, 16'h0526}};
	ccds_sequencer ccds_sequencer_i (.ref_clk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.external_trigger_input, .adcData, .vShift_r, .hShift_r,
		.adcConvert_r, .shutterOpen_r, .gainHigh_r, .pixData_r,
		.pixValid_r, .frameDone_r);
	ccds_ccd_model ccds_ccd_model_i (.ref_clk, .rst, .hShift_r,
		.adcConvert_r, .level, .adcData);
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// both write channels offered together, bready held till answer
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, 32'h0);
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rdVal = s_axi_rdata;
		chk(s_axi_rresp, 32'h0);
		s_axi_rready <= 1'h0;
	endtask
	task automatic waitDone();
		do @(posedge ref_clk); while (frameDone_r !== 1'h1);
		// one more edge so the monitor has counted the last sample
		@(posedge ref_clk);
	endtask
	// trigger pulse; falling select must not fire on the rise
	task automatic pulse(input logic [1:0] kind);
		repeat (24) @(posedge ref_clk);
		chk(shutterOpen_r, 32'h0);
		external_trigger_input <= 1'h1;
		repeat (kind == 2'h3 ? 200 : 24) @(posedge ref_clk);
		chk(shutterOpen_r, kind != 2'h2);
		chk(nPix, 32'h0);
		external_trigger_input <= 1'h0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// sample monitor: count, pacing, content, gain
	always @(posedge ref_clk) begin
		gap++;
		if (pixValid_r === 1'h1) begin
			nPix++;
			if (gap < minGap) minGap = gap;
			gap = 0;
			if (chkOn) chk(pixData_r, expD);
			if (chkOn) chk(gainHigh_r, expG);
		end
	end
	// cut a hang well past the longest expected run
	initial begin
		repeat (40000) @(posedge ref_clk);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'h0;
		chk({shutterOpen_r, pixValid_r, s_axi_awready}, 32'h1);
		rd(`CCDS_ADDR_EXPO);
		chk(rdVal, `CCDS_EXPO_RESET);
		rd(`CCDS_ADDR_GEOM);
		chk(rdVal, `CCDS_GEOM_RESET);
		// tiny 2x2 frame with short exposure keeps runs brief
		wr(`CCDS_ADDR_GEOM, 32'h0002_0002);
		wr(`CCDS_ADDR_EXPO, 32'h0000_0010);
		chkOn = 1'h1;
		foreach (rows[i]) begin
			level <= rows[i].lvl;
			expD = rows[i].pix;
			expG = rows[i].ctrl[3];
			nPix = 0;
			minGap = 99999;
			wr(`CCDS_ADDR_CTRL, {24'h0, rows[i].ctrl});
			t0 = $time;
			if (rows[i].trg != 2'h0) pulse(rows[i].trg);
			waitDone();
			len[i] = ($time - t0) / 25;
			chk(nPix, 32'h4);
			chk(minGap, rows[i].ctrl[1] ? `CCDS_FAST_CYC : `CCDS_SLOW_CYC);
		end
		chk(len[2] - len[0], `CCDS_VSHIFT_CYC + 2 * `CCDS_FAST_CYC);
		// leave start-once: the repeated frame must still end
		chkOn = 1'h0;
		wr(`CCDS_ADDR_CTRL, 32'h0000_0002);
		waitDone();
		// gain request mid-frame must wait for the next frame
		chkOn = 1'h1;
		expG = 1'h0;
		wr(`CCDS_ADDR_CTRL, 32'h0000_0003);
		repeat (40) @(posedge ref_clk);
		wr(`CCDS_ADDR_CTRL, 32'h0000_000a);
		waitDone();
		nPix = 0;
		pulse(2'h2);
		repeat (100) @(posedge ref_clk);
		chk(shutterOpen_r, 32'h0);
		chk(nPix, 32'h0);
		// one kept column per row: the rest are stepped and dropped
		wr(`CCDS_ADDR_ROI, 32'h0001_0001);
		wr(`CCDS_ADDR_CTRL, 32'h0000_0003);
		waitDone();
		chk(nPix, 32'h2);
		// second reset in mid-frame
		wr(`CCDS_ADDR_CTRL, 32'h0000_0003);
		repeat (60) @(posedge ref_clk);
		rst <= 1'h1;
		repeat (8) @(posedge ref_clk);
		chk({shutterOpen_r, vShift_r, pixValid_r}, 32'h0);
		rst <= 1'h0;
		rd(`CCDS_ADDR_GEOM);
		chk(rdVal, `CCDS_GEOM_RESET);
		report_and_stop();
	end
endmodule // tb_ccd_full_frame_readout_sequencer
